// ### hw/dram_ctrl.sv
`timescale 1ns/1ps
module dram_ctrl #(
    parameter int PWRUP  = dram_ctrl_pkg::PWRUP_CYC,
    parameter int REFPER = dram_ctrl_pkg::REF_CYC
) (
    input  wire logic                            mclk_in,      // 40 MHz clock
    input  wire logic                            reset_in,     // sync reset, high
    input  wire logic                            req_valid_in, // request present
    input  wire dram_ctrl_pkg::req_s             req_in,       // request contents
    output logic                                 req_ready_out,// request taken
    output logic                                 rdata_valid_out, // read data pulse
    output logic [dram_ctrl_pkg::DATA_BITS-1:0]  rdata_out,    // read data
    output logic                                 init_done_out,// device usable
    output logic                                 ras_n_out,    // row strobe
    output logic                                 cas_n_out,    // column strobe
    output logic                                 we_n_out,     // write enable
    output logic                                 oe_n_out,     // output enable
    output logic [dram_ctrl_pkg::ROW_BITS-1:0]   mux_addr_out, // address pins
    input  wire logic [dram_ctrl_pkg::DATA_BITS-1:0] data_io_in, // data pins in
    output logic [dram_ctrl_pkg::DATA_BITS-1:0]  data_io_out,  // data pins out
    output logic                                 data_io_oe_out // data drive enable
);
    import dram_ctrl_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [10:0] {
        S_PWRUP = 11'b000_0000_0001,
        S_INIT  = 11'b000_0000_0010,
        S_IDLE  = 11'b000_0000_0100,
        S_ROW   = 11'b000_0000_1000,
        S_COL   = 11'b000_0001_0000,
        S_READ  = 11'b000_0010_0000,
        S_OEOFF = 11'b000_0100_0000,
        S_WPUL  = 11'b000_1000_0000,
        S_CASHI = 11'b001_0000_0000,
        S_PRE   = 11'b010_0000_0000,
        S_REF   = 11'b100_0000_0000
    } state_e;

    state_e              state;
    logic [31:0]         timer;
    logic [3:0]          init_count;
    logic [ROW_BITS-1:0] ref_row;
    logic [ROW_BITS-1:0] open_row;
    req_s                cur;
    logic                ref_due;
    logic                ref_ack;

    function automatic logic [ROW_BITS-1:0] row_of(input logic [ADDR_BITS-1:0] a);
        row_of = a[ADDR_BITS-1:COL_BITS];
    endfunction

    // column bits ride on mux_addr[6:1]
    function automatic logic [ROW_BITS-1:0] col_of(input logic [ADDR_BITS-1:0] a);
        col_of = {1'b0, a[COL_BITS-1:0], 1'b0};
    endfunction

    dram_refresh_timer #(
        .PERIOD (REFPER)
    ) u_refresh (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .ack_in   (ref_ack),
        .due_out  (ref_due)
    );

    wire timer_done = (timer == 32'h0000_0000);
    wire same_page  = req_valid_in && req_in.page && (row_of(req_in.addr) == open_row) && !ref_due;
    assign ref_ack  = (state == S_REF) && timer_done;

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state      <= S_PWRUP;
            timer      <= 32'(PWRUP);
            init_count <= 4'h0;
            ref_row    <= 8'h00;
            open_row   <= 8'h00;
            cur        <= '0;
        end else begin
            if (!timer_done) begin
                timer <= timer - 32'h0000_0001;
            end
            unique case (state)
                S_PWRUP: begin
                    if (timer_done) begin // [R21]
                        state <= S_INIT;
                        timer <= 32'(T_RAS_CYC);
                    end
                end
                S_INIT: begin
                    // ras-only cycles during init, alternating low and precharge
                    if (timer_done) begin
                        if (!ras_n_out) begin
                            timer      <= 32'(T_RP_CYC);
                            init_count <= init_count + 4'h1;
                        end else if (init_count == 4'(INIT_CYCLES)) begin // [R21]
                            state <= S_IDLE;
                        end else begin
                            timer <= 32'(T_RAS_CYC);
                        end
                    end
                end
                S_IDLE: begin
                    if (ref_due) begin // [R17]
                        state <= S_REF;
                        timer <= 32'(T_RAS_CYC);
                    end else if (req_valid_in) begin
                        cur      <= req_in;
                        open_row <= row_of(req_in.addr);
                        state    <= S_ROW;
                        timer    <= 32'(T_RCD_CYC);
                    end
                end
                S_REF: begin
                    if (timer_done) begin // [R18]
                        ref_row <= ref_row + 8'h01;
                        state   <= S_PRE;
                        timer   <= 32'(T_RP_CYC);
                    end
                end
                S_ROW: begin
                    if (timer_done) begin // [R2]
                        state <= S_COL;
                        timer <= (cur.op == OP_WRITE) ? 32'(T_CAS_CYC) : 32'(T_ACC_CYC);
                    end
                end
                S_COL: begin
                    if (timer_done) begin
                        if (cur.op == OP_WRITE) begin
                            state <= S_CASHI;
                            timer <= 32'(T_CP_CYC);
                        end else begin
                            state <= S_READ;
                        end
                    end
                end
                S_READ: begin
                    if (cur.op == OP_RMW) begin // [R23]
                        state <= S_OEOFF;
                        timer <= 32'(T_OFF_CYC);
                    end else begin
                        state <= S_CASHI;
                        timer <= 32'(T_CP_CYC);
                    end
                end
                S_OEOFF: begin
                    if (timer_done) begin // [R10]
                        state <= S_WPUL;
                        timer <= 32'(T_WP_CYC);
                    end
                end
                S_WPUL: begin
                    if (timer_done) begin // [R9]
                        state <= S_CASHI;
                        timer <= 32'(T_CP_CYC);
                    end
                end
                S_CASHI: begin
                    if (timer_done) begin
                        if (same_page) begin // [R19]
                            cur   <= req_in;
                            state <= S_COL;
                            timer <= (req_in.op == OP_WRITE) ? 32'(T_CAS_CYC) : 32'(T_ACC_CYC);
                        end else begin
                            state <= S_PRE;
                            timer <= 32'(T_RP_CYC);
                        end
                    end
                end
                S_PRE: begin
                    if (timer_done) begin // [R22]
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // pins
    // ****************************************
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ras_n_out <= 1'b1;
        end else if (state == S_INIT && timer_done) begin
            ras_n_out <= !ras_n_out && !(init_count == 4'(INIT_CYCLES));
        end else if ((state == S_ROW && timer == 32'(T_RCD_CYC)) || (state == S_REF && timer == 32'(T_RAS_CYC))) begin
            ras_n_out <= 1'b0; // [R1] row address already set up in idle
        end else if ((state == S_REF && timer_done) || (state == S_CASHI && timer_done && !same_page)) begin
            ras_n_out <= 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            mux_addr_out <= 8'h00;
        end else if (state == S_IDLE) begin
            mux_addr_out <= ref_due ? ref_row : row_of(req_in.addr); // [R3]
        end else if (state == S_ROW && timer != 32'(T_RCD_CYC)) begin
            mux_addr_out <= col_of(cur.addr); // [R3] row held a cycle past the strobe fall
        end else if (state == S_CASHI && timer_done && same_page) begin
            mux_addr_out <= col_of(req_in.addr); // [R3]
        end
    end

    // column strobe falls two cycles after the column address settles, one cycle in page mode
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            cas_n_out <= 1'b1;
        end else if (state == S_ROW && timer_done) begin
            cas_n_out <= 1'b1;
        end else if (state == S_COL) begin
            cas_n_out <= 1'b0; // [R2] [R20] one decoded strobe per device
        end else if (state == S_READ && cur.op != OP_RMW) begin
            cas_n_out <= 1'b1; // [R14]
        end else if (state == S_WPUL && timer_done) begin
            cas_n_out <= 1'b1;
        end else if (state == S_COL && timer_done && cur.op == OP_WRITE) begin
            cas_n_out <= 1'b1;
        end else if (state == S_CASHI || state == S_REF || state == S_IDLE || state == S_INIT) begin
            cas_n_out <= 1'b1; // [R18]
        end
    end

    // early write: we low before cas falls, data set up with the address
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            we_n_out <= 1'b1;
        end else if (state == S_ROW) begin
            we_n_out <= (cur.op != OP_WRITE); // [R7] [R8]
        end else if (state == S_OEOFF && timer_done) begin
            we_n_out <= 1'b0; // [R8] [R23]
        end else if (state == S_WPUL && timer_done) begin
            we_n_out <= 1'b1;
        end else if (state == S_CASHI && timer_done && same_page) begin
            we_n_out <= (req_in.op != OP_WRITE);
        end else if (state == S_PRE || state == S_IDLE) begin
            we_n_out <= 1'b1; // [R5]
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            oe_n_out <= 1'b1;
        end else if (state == S_COL && cur.op != OP_WRITE) begin
            oe_n_out <= 1'b0; // [R12]
        end else begin
            oe_n_out <= 1'b1; // [R10]
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            data_io_oe_out <= 1'b0;
            data_io_out    <= 4'h0;
        end else if ((state == S_ROW && cur.op == OP_WRITE) || (state == S_OEOFF && timer < 32'h0000_0002)) begin
            data_io_oe_out <= 1'b1; // [R9] [R10] data settles before write enable falls
            data_io_out    <= cur.wdata;
        end else if (state == S_CASHI && timer_done && same_page && req_in.op == OP_WRITE) begin
            data_io_oe_out <= 1'b1;
            data_io_out    <= req_in.wdata;
        end else if (state == S_CASHI || state == S_PRE || state == S_IDLE || state == S_READ) begin
            data_io_oe_out <= 1'b0; // [R6]
        end
    end

    // ****************************************
    // user side
    // ****************************************
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rdata_valid_out <= 1'b0;
            rdata_out       <= 4'h0;
        end else begin
            rdata_valid_out <= (state == S_READ);
            if (state == S_READ) begin
                rdata_out <= data_io_in; // [R13] [R15]
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            req_ready_out <= 1'b0;
            init_done_out <= 1'b0;
        end else begin
            req_ready_out <= (state == S_IDLE && !ref_due && req_valid_in)
                             || (state == S_CASHI && timer_done && same_page);
            if (state == S_INIT && timer_done && ras_n_out && init_count == 4'(INIT_CYCLES)) begin
                init_done_out <= 1'b1; // [R21]
            end
        end
    end
endmodule

// ### hw/dram_ctrl_pkg.sv
// How it works
// R1 - controller drives 8 row bits on mux_addr, device latches on row strobe fall
// R2 - controller drives 6 column bits on mux_addr[6:1], latched on column strobe fall
// R3 - address is stable before the strobe that latches it falls
// R4 - row strobe wakes sense amps and row decoder; column strobe wakes column side
// R5 - write enable high means read, low means write
// R6 - during read the device ignores data pins and writes nothing
// R7 - early write keeps device outputs off whole cycle even with output enable low
// R8 - write data latched on later of column strobe fall or write enable fall
// R9 - delayed or read-modify-write: hold data stable around write enable fall
// R10 - raise output enable before driving write data in delayed write
// R11 - device outputs stay off until column strobe falls
// R12 - device drives only with both strobes and output enable low
// R13 - read data valid after access delays, held while strobe and enable low
// R14 - device outputs turn off when column strobe or output enable rises
// R15 - read data has the polarity in which it was written
// R16 - addresses and write data latched, read data not latched
// R17 - strobe all 256 rows within every 4 ms refresh period
// R18 - refresh with row strobe only, column strobe held high
// R19 - page mode keeps row low and cycles column strobe over 64 columns
// R20 - row strobe shared by several devices, column strobe decoded per device
// R21 - after power-up hold row strobe high 100 us then eight row cycles
// R22 - plain and read-modify-write cycles may mix in any order
// R23 - read-modify-write reads, raises enable, drives data, drops write enable
package dram_ctrl_pkg;
    localparam int ROW_BITS   = 8;
    localparam int COL_BITS   = 6;
    localparam int DATA_BITS  = 4;
    localparam int ADDR_BITS  = ROW_BITS + COL_BITS;
    localparam int CLK_MHZ    = 40;
    localparam int CLK_NS     = 25;
    // device timings in ns (slower grade), rounded up to cycles
    localparam int T_RP_NS    = 120;
    localparam int T_RAS_NS   = 200;
    localparam int T_CAS_NS   = 120;
    localparam int T_CP_NS    = 80;
    localparam int T_RCD_NS   = 50;
    localparam int T_ACC_NS   = 200;
    localparam int T_OFF_NS   = 40;
    localparam int T_WP_NS    = 50;
    localparam int T_RP_CYC   = (T_RP_NS  + CLK_NS - 1) / CLK_NS;
    localparam int T_RAS_CYC  = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_CAS_CYC  = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_CP_CYC   = (T_CP_NS  + CLK_NS - 1) / CLK_NS;
    localparam int T_RCD_CYC  = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_OFF_CYC  = (T_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_WP_CYC   = (T_WP_NS  + CLK_NS - 1) / CLK_NS;
    localparam int PWRUP_US   = 100;
    localparam int PWRUP_CYC  = PWRUP_US * CLK_MHZ;
    localparam int INIT_CYCLES = 8;
    localparam int REF_ROWS   = 256;
    localparam int REF_MS     = 4;
    // a row every REF_MS/REF_ROWS, rounded down
    localparam int REF_CYC    = (REF_MS * 1000 * CLK_MHZ * 1000) / REF_ROWS / 1000;

    typedef enum logic [1:0] {
        OP_READ  = 2'b00,
        OP_WRITE = 2'b01,
        OP_RMW   = 2'b10
    } op_e;

    typedef struct packed {
        op_e                    op;
        logic [ADDR_BITS-1:0]   addr;
        logic [DATA_BITS-1:0]   wdata;
        logic                   page;
    } req_s;

    typedef struct packed {
        logic                   ras_n;
        logic                   cas_n;
        logic                   we_n;
        logic                   oe_n;
        logic [ROW_BITS-1:0]    mux_addr;
    } pins_s;
endpackage

// ### hw/dram_refresh_timer.sv
`timescale 1ns/1ps
module dram_refresh_timer #(
    parameter int PERIOD = dram_ctrl_pkg::REF_CYC
) (
    input  wire logic mclk_in,   // clock
    input  wire logic reset_in,  // sync reset
    input  wire logic ack_in,    // refresh done
    output logic      due_out    // refresh pending
);
    import dram_ctrl_pkg::*;
    logic [15:0] count;

    // one row refresh request per interval, pending until served
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            count <= 16'h0000;
        end else if (count == 16'(PERIOD - 1)) begin
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            due_out <= 1'b0;
        end else if (count == 16'(PERIOD - 1)) begin
            due_out <= 1'b1;
        end else if (ack_in) begin
            due_out <= 1'b0;
        end
    end
endmodule

// ### tb/dram_ctrl_sva.sv
`timescale 1ns/1ps
module dram_ctrl_sva
    import dram_ctrl_pkg::*;
#(
    parameter int PWRUP  = PWRUP_CYC,
    parameter int REFPER = REF_CYC
) (
    input wire logic                 mclk_in,        // clock
    input wire logic                 reset_in,       // sync reset
    input wire logic                 init_done_out,  // device usable
    input wire logic                 ras_n_out,      // row strobe
    input wire logic                 cas_n_out,      // column strobe
    input wire logic                 we_n_out,       // write enable
    input wire logic                 oe_n_out,       // output enable
    input wire logic [ROW_BITS-1:0]  mux_addr_out,   // address pins
    input wire logic [DATA_BITS-1:0] data_io_out,    // data pins out
    input wire logic                 data_io_oe_out  // data drive enable
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    int   cyc;
    int   n_fall;
    int   gap;
    logic seen_fall;
    // ****************************************
    // helper counters
    // ****************************************
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            cyc       <= 0;
            n_fall    <= 0;
            gap       <= 0;
            seen_fall <= 1'b0;
        end else begin
            if (cyc <= PWRUP) cyc <= cyc + 1;
            if (!ras_n_out) seen_fall <= 1'b1;
            if ($fell(ras_n_out) && n_fall < 15) n_fall <= n_fall + 1;
            gap <= ($fell(ras_n_out) || !init_done_out) ? 0 : gap + 1;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    property p_row_hold; $fell(ras_n_out) |-> $stable(mux_addr_out); endproperty
    a_row_hold: assert property (p_row_hold) else $error("row address moved at row strobe fall");
    property p_col_addr; $fell(cas_n_out) |-> !ras_n_out && !mux_addr_out[7] && !mux_addr_out[0]; endproperty
    a_col_addr: assert property (p_col_addr) else $error("bad column strobe");
    property p_col_stable; $fell(cas_n_out) |-> $stable(mux_addr_out); endproperty
    a_col_stable: assert property (p_col_stable) else $error("column address not set up");
    property p_oe_strobes; !oe_n_out |-> !ras_n_out && !cas_n_out; endproperty
    a_oe_strobes: assert property (p_oe_strobes) else $error("output enable without strobes");
    property p_drive; data_io_oe_out |-> oe_n_out && $past(oe_n_out); endproperty
    a_drive: assert property (p_drive) else $error("data driven while device may drive");
    property p_early; $fell(cas_n_out) && !we_n_out |-> oe_n_out && data_io_oe_out; endproperty
    a_early: assert property (p_early) else $error("early write data missing");
    property p_late_we;
        $fell(we_n_out) && !cas_n_out |-> oe_n_out && data_io_oe_out && $past(data_io_oe_out)
            && $stable(data_io_out) ##1 $stable(data_io_out);
    endproperty
    a_late_we: assert property (p_late_we) else $error("delayed write data not held");
    property p_pwrup; $fell(ras_n_out) && !seen_fall |-> cyc >= PWRUP - 1; endproperty
    a_pwrup: assert property (p_pwrup) else $error("row strobe fell too soon after power up");
    property p_init_cnt; $rose(init_done_out) |-> n_fall >= 8; endproperty
    a_init_cnt: assert property (p_init_cnt) else $error("too few init row cycles");
    property p_init_cas; !init_done_out |-> cas_n_out; endproperty
    a_init_cas: assert property (p_init_cas) else $error("column strobe during init");
    property p_refresh; gap <= REFPER + 100; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh gap too long");
    c_init: cover property ($rose(init_done_out));
    c_early: cover property ($fell(cas_n_out) && !we_n_out);
    c_late: cover property ($fell(we_n_out) && !cas_n_out);
endmodule

// ### tb/dram_dev_model.sv
`timescale 1ns/1ps
module dram_dev_model
    import dram_ctrl_pkg::*;
#(
    parameter int ACC_NS = 60
) (
    input  wire logic                 ras_n_in,   // row strobe
    input  wire logic                 cas_n_in,   // column strobe
    input  wire logic                 we_n_in,    // write enable
    input  wire logic                 oe_n_in,    // output enable
    input  wire logic [ROW_BITS-1:0]  addr_in,    // address pins
    input  wire logic [DATA_BITS-1:0] dq_in,      // resolved data pins
    output logic      [DATA_BITS-1:0] dq_out,     // read data
    output logic                      dq_oe_out,  // device drives
    output int                        ras_falls,  // row strobes seen
    output int                        ras_only,   // cycles without column strobe
    output int                        writes      // array writes
);
    logic [DATA_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];
    logic [ROW_BITS-1:0]  row;
    logic [COL_BITS-1:0]  col;
    logic                 early;
    logic                 cas_seen;
    initial begin
        row = '0; col = '0; early = 1'b0; cas_seen = 1'b0;
        ras_falls = 0; ras_only = 0; writes = 0;
    end
    // inputs are looked at 1 ns after an edge, once all pins have settled
    always @(negedge ras_n_in) begin
        #1;
        row = addr_in;
        ras_falls++;
        cas_seen = 1'b0;
    end
    always @(posedge ras_n_in) if (!cas_seen) ras_only++;
    always @(negedge cas_n_in) begin
        #1;
        if (!ras_n_in) begin
            col = addr_in[COL_BITS:1];
            cas_seen = 1'b1;
            early = !we_n_in;
            if (!we_n_in) begin
                mem[{row, col}] = dq_in;
                writes++;
            end
        end
    end
    always @(negedge we_n_in) begin
        #1;
        if (!cas_n_in && !ras_n_in) begin
            mem[{row, col}] = dq_in;
            writes++;
        end
    end
    always @(posedge cas_n_in) early = 1'b0;
    assign #(ACC_NS) dq_out = mem[{row, col}];
    assign dq_oe_out = !ras_n_in && !cas_n_in && !oe_n_in && !early;
endmodule

// ### tb/dram_16k_by_4_strobe_interface_bench.sv
`timescale 1ns/1ps
module dram_16k_by_4_strobe_interface_bench;
    import dram_ctrl_pkg::*;
    localparam int PWRUP  = 50;
    localparam int REFPER = 200;
    logic                 mclk, reset, req_valid, req_ready, rdata_valid, init_done;
    logic                 ras_n, cas_n, we_n, oe_n, ctl_oe, mdl_oe;
    req_s                 req;
    logic [ROW_BITS-1:0]  mux_addr;
    logic [DATA_BITS-1:0] rdata, ctl_d, mdl_q, dq, dq_last, q;
    int                   n_errors, tests_run, cycles, ras_falls, ras_only, writes;
    `define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
    dram_ctrl #(.PWRUP(PWRUP), .REFPER(REFPER)) i_dut (.mclk_in(mclk), .reset_in(reset),
        .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready), .rdata_valid_out(rdata_valid),
        .rdata_out(rdata), .init_done_out(init_done), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
        .oe_n_out(oe_n), .mux_addr_out(mux_addr), .data_io_in(dq), .data_io_out(ctl_d), .data_io_oe_out(ctl_oe));
    dram_dev_model i_mem (.ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(mux_addr),
        .dq_in(dq), .dq_out(mdl_q), .dq_oe_out(mdl_oe), .ras_falls(ras_falls), .ras_only(ras_only), .writes(writes));
    // a released data bus shows the inverse of its last value
    assign dq = ctl_oe ? ctl_d : (mdl_oe ? mdl_q : ~dq_last);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        dq_last <= dq;
        cycles++;
        if (!reset) `CHECK(ctl_oe & mdl_oe, 1'b0)
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("errors %0d of %0d comparisons", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic access(input op_e op, input logic [ADDR_BITS-1:0] a, input logic [DATA_BITS-1:0] d,
                          input logic pg);
        int k;
        int w0;
        w0 = writes;
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= '{op, a, d, pg};
        k = 0;
        do begin @(posedge mclk); k++; end while (req_ready !== 1'b1 && k < 3000);
        `CHECK(req_ready, 1'b1)
        req_valid <= 1'b0;
        k = 0;
        if (op != OP_WRITE) begin
            do begin @(posedge mclk); k++; end while (rdata_valid !== 1'b1 && k < 200);
            q = rdata;
        end
        if (op != OP_READ) begin
            while (writes == w0 && k < 200) begin @(posedge mclk); k++; end
            `CHECK(mem_at(a), d)
        end
    endtask
    function automatic logic [DATA_BITS-1:0] mem_at(input logic [ADDR_BITS-1:0] a);
        return i_mem.mem[a];
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_init();
        int k;
        k = 0;
        while (init_done !== 1'b1 && k < 2000) begin @(posedge mclk); k++; end
        `CHECK(init_done, 1'b1)
        `CHECK(ras_falls >= INIT_CYCLES, 1'b1)
        `CHECK(writes, 0)
    endtask
    task automatic t_write_read();
        logic [ADDR_BITS-1:0] adr [4] = '{14'h0000, 14'h3FFF, 14'h2A15, 14'h15EA};
        logic [DATA_BITS-1:0] dat [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
        int w0;
        foreach (adr[i]) access(OP_WRITE, adr[i], dat[i], 1'b0);
        w0 = writes;
        foreach (adr[i]) begin
            access(OP_READ, adr[i], 4'h0, 1'b0);
            `CHECK(q, dat[i])
        end
        `CHECK(writes, w0)
    endtask
    task automatic t_rmw();
        access(OP_WRITE, 14'h1234, 4'h3, 1'b0);
        access(OP_RMW, 14'h1234, 4'hC, 1'b0);
        `CHECK(q, 4'h3)
        access(OP_READ, 14'h1234, 4'h0, 1'b0);
        `CHECK(q, 4'hC)
    endtask
    task automatic t_page();
        access(OP_WRITE, 14'h2040, 4'h6, 1'b1);
        access(OP_WRITE, 14'h207F, 4'h9, 1'b1);
        access(OP_READ, 14'h2040, 4'h0, 1'b1);
        `CHECK(q, 4'h6)
        access(OP_READ, 14'h207F, 4'h0, 1'b1);
        `CHECK(q, 4'h9)
    endtask
    task automatic t_refresh();
        int r0;
        int w0;
        r0 = ras_only;
        w0 = writes;
        repeat (3 * REFPER) @(posedge mclk);
        `CHECK(ras_only - r0 >= 2, 1'b1)
        `CHECK(writes, w0)
    endtask
    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req = '0;
        dq_last = '0;
        q = '0;
        n_errors = 0;
        tests_run = 0;
        cycles = 0;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        t_init();
        t_write_read();
        t_rmw();
        t_page();
        t_refresh();
        report_and_stop();
    end
endmodule
bind dram_ctrl dram_ctrl_sva #(.PWRUP(PWRUP), .REFPER(REFPER)) i_sva (.mclk_in(mclk_in), .reset_in(reset_in),
    .init_done_out(init_done_out), .ras_n_out(ras_n_out), .cas_n_out(cas_n_out), .we_n_out(we_n_out),
    .oe_n_out(oe_n_out), .mux_addr_out(mux_addr_out), .data_io_out(data_io_out), .data_io_oe_out(data_io_oe_out));
